// ===== logic/smdc_pkg.sv
`default_nettype none
// Shared constants and carriers of the six-mode down counter
package smdc_pkg;

  // Counter operating modes (modes 6 and 7 alias to 2 and 3)
  localparam logic [2:0] MODE_INT_TC    = 3'h0; // Interrupt on terminal count
  localparam logic [2:0] MODE_ONE_SHOT  = 3'h1; // Retriggerable one-shot
  localparam logic [2:0] MODE_RATE_GEN  = 3'h2; // Rate generator
  localparam logic [2:0] MODE_SQUARE    = 3'h3; // Square wave
  localparam logic [2:0] MODE_SW_STROBE = 3'h4; // Software strobe
  localparam logic [2:0] MODE_HW_STROBE = 3'h5; // Hardware strobe

  // Byte access selections of the count write
  localparam logic [1:0] RW_LATCH = 2'h0; // Latch command, not handled here
  localparam logic [1:0] RW_LSB   = 2'h1; // Low byte only
  localparam logic [1:0] RW_MSB   = 2'h2; // High byte only
  localparam logic [1:0] RW_BOTH  = 2'h3; // Low byte then high byte

  // Field positions of the control word byte
  localparam int CW_BCD_POS  = 0; // BCD select
  localparam int CW_MODE_POS = 1; // Mode, three bits
  localparam int CW_RW_POS   = 4; // Byte access select, two bits

  // Reset values
  localparam logic [15:0] CE_RST   = 16'h0000; // Counting element
  localparam logic [15:0] CR_RST   = 16'h0000; // Count holding register
  localparam logic [2:0]  MODE_RST = 3'h0;     // Mode after reset
  localparam logic        OUT_RST  = 1'b1;     // Output line after reset

  // Special counter values
  localparam logic [15:0] CE_ONE  = 16'h0001; // Rate generator low point
  localparam logic [15:0] CE_TWO  = 16'h0002; // Square wave reload point
  localparam logic [15:0] CE_ZERO = 16'h0000; // Terminal count
  localparam logic [15:0] LSB_CLR = 16'hfffe; // Mask for low bit of count

  // Control word as written by software
  typedef struct packed {
    logic       byte_access_sel_hi; // Upper byte access select
    logic       byte_access_sel_lo; // Lower byte access select
    logic [2:0] mode;               // Operating mode
    logic       bcd;                // Decimal counting
  } smdc_cw_t;

  // Whole state of the counter channel
  typedef struct packed {
    logic       clk_prev;  // Counter clock of the previous cycle
    logic       smp_gate;  // Gate level taken on the counter clock rise
    logic       smp_trig;  // Trigger taken on the counter clock rise
    logic       smp_load;  // Load request taken on the counter clock rise
    logic       load_pend; // Count waiting for the next rise
    logic [2:0] mode;      // Active mode
    logic       bcd;       // Decimal counting
    logic [1:0] rw;        // Byte access selection
    logic       hi_next;   // Next two-byte write is the high byte
    logic [7:0] lo_stage;  // Low byte held until the high byte comes
    logic [15:0] cr;       // Count holding register
    logic [15:0] ce;       // Counting element
    logic       run;       // Element has been loaded and may count
    logic       frz;       // Frozen between two count bytes
    logic       armed;     // A complete count has been written
    logic       odd;       // Loaded square wave count was odd
    logic       null_cnt;  // Holding register not yet moved to element
    logic       out;       // Output line
  } smdc_state_t;

endpackage : smdc_pkg
`default_nettype wire

// ===== logic/smdc_gate_cap.sv
`default_nettype none
// Gate rising edge capture flip-flop
module smdc_gate_cap (
  input  wire logic clk,    // System clock
  input  wire logic rst_n,  // Synchronised reset, active low
  input  wire logic gate,   // Gate level
  input  wire logic clr,    // Clear after the flag was sampled
  output var  logic flag    // Captured rising edge
);

  // State of the capture: previous gate and the flag itself
  typedef struct packed {
    logic gate_prev; // Gate of the previous cycle
    logic flag;      // Edge seen and not yet sampled
  } smdc_cap_t;

  smdc_cap_t st_r;   // Registered state
  smdc_cap_t st_nxt; // Next state

  // Set on a rising edge; a new edge wins over the clear
  always_comb begin
    st_nxt           = st_r;
    st_nxt.gate_prev = gate;
    st_nxt.flag      = (gate & ~st_r.gate_prev) | (st_r.flag & ~clr);
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag = st_r.flag;

endmodule : smdc_gate_cap
`default_nettype wire

// ===== logic/smdc_counter.sv
`default_nettype none
// Operation
// - Mode 0 control word drives output low
// - Mode 0 loads next cycle, decrements after
// - Mode 0 gate low holds count, output unchanged
// - Mode 0 output high at zero, stays high
// - Mode 0 count write lowers output, reloads
// - Mode 0 load happens even with gate low
// - Same-mode control word stops counting
// - Mode 1 trigger loads, output low
// - Mode 1 output high at zero; retrigger reloads
// - Mode 2 low one clock at one
// - Mode 2 new count at next reload
// - Modes 2,3 gate low: output high, reload
// - Mode 3 even count: step two, toggle
// - Mode 3 odd count: load minus one
// - Mode 3 new count at next toggle
// - Modes 4,5 one clock low at zero
// - Mode 4 count write reloads next clock
// - Mode 4 gate enables counting only
// - Mode 5 loads only after gate trigger
// - Mode 5 low pulse N+1 after trigger
// - Sample on counter rise, act on fall
// - Gate edge flag cleared after sampling
// - Zero count means full range
module smdc_counter (
  input  wire logic              clk,        // System clock, 40 MHz
  input  wire logic              arst_n,     // Asynchronous reset, low
  input  wire logic              ctr_clk,    // Counter clock level
  input  wire logic              gate,       // Gate level
  input  wire logic              cw_wr,      // Control word write strobe
  input  wire smdc_pkg::smdc_cw_t counter_control_word, // Written word
  input  wire logic              cnt_wr,     // Count byte write strobe
  input  wire logic [7:0]        cnt_byte,   // Count byte written
  output var  logic              ctr_out,    // Output line
  output var  logic [15:0]       ce_value,   // Counting element
  output var  logic              null_count  // Count not yet loaded
);

  logic [1:0]           rst_sync_r; // Reset release synchroniser
  logic                 rst_n;      // Synchronised reset
  smdc_pkg::smdc_state_t st_r;      // Registered state
  smdc_pkg::smdc_state_t st_nxt;    // Next state
  logic                 trig_flag;  // Captured gate edge
  logic                 rise;       // Counter clock rising edge
  logic                 fall;       // Counter clock falling edge
  logic [2:0]           mode_eff;   // Mode with aliases folded
  logic [15:0]          dec_one;    // Element minus one
  logic [15:0]          dec_two;    // Element minus two
  logic [15:0]          cr_half;    // Count with its low bit cleared
  logic                 cnt_done;   // This write completes a count
  logic [15:0]          cr_new;     // Count formed by this write

  // Reset is released through two flip-flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Decrement by one, binary or four decimal digits
  function automatic logic [15:0] smdc_dec(input logic [15:0] v,
                                           input logic        bcd);
    logic [15:0] r;
    logic        borrow;
    r      = v;
    borrow = 1'b1;
    if (!bcd) begin
      r = v - 16'h0001;
    end else begin
      for (int i = 0; i < 4; i++) begin
        // Each digit borrows only while the lower ones were zero
        if (borrow) begin
          if (r[4*i +: 4] == 4'h0) begin
            r[4*i +: 4] = 4'h9;
          end else begin
            r[4*i +: 4] = r[4*i +: 4] - 4'h1;
            borrow      = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction : smdc_dec

  // Gate edge capture, cleared on each counter clock rise
  smdc_gate_cap u_gate_cap (
    .clk   (clk),
    .rst_n (rst_n),
    .gate  (gate),
    .clr   (rise),
    .flag  (trig_flag)
  );

  // Edge detection of the counter clock and helper values
  always_comb begin
    rise     = ctr_clk & ~st_r.clk_prev;
    fall     = ~ctr_clk & st_r.clk_prev;
    mode_eff = st_r.mode[1] ? {1'b0, st_r.mode[1:0]} : st_r.mode;
    // Zero wraps to the top, so a zero count spans the full range
    dec_one  = smdc_dec(st_r.ce, st_r.bcd);
    dec_two  = smdc_dec(dec_one, st_r.bcd);
    cr_half  = st_r.cr & smdc_pkg::LSB_CLR;
    // Count formed by the current byte write
    cnt_done = 1'b0;
    cr_new   = st_r.cr;
    case (st_r.rw)
      smdc_pkg::RW_LSB: begin
        cnt_done = 1'b1;
        cr_new   = {8'h00, cnt_byte};
      end
      smdc_pkg::RW_MSB: begin
        cnt_done = 1'b1;
        cr_new   = {cnt_byte, 8'h00};
      end
      smdc_pkg::RW_BOTH: begin
        // Old count stays in force until the high byte arrives
        cnt_done = st_r.hi_next;
        cr_new   = st_r.hi_next ? {cnt_byte, st_r.lo_stage} : st_r.cr;
      end
      default: begin
        cnt_done = 1'b0;
        cr_new   = st_r.cr;
      end
    endcase
  end

  // Next state: sampling, counting, then software writes
  always_comb begin
    st_nxt          = st_r;
    st_nxt.clk_prev = ctr_clk;

    // Rising edge takes the gate, the trigger and the load request
    if (rise) begin
      st_nxt.smp_gate  = gate;
      st_nxt.smp_trig  = trig_flag;
      st_nxt.smp_load  = st_r.load_pend;
      st_nxt.load_pend = 1'b0;
    end

    // Falling edge acts on what the rise sampled
    if (fall) begin
      case (mode_eff)
        smdc_pkg::MODE_INT_TC: begin
          if (st_r.smp_load) begin
            // Load even with gate low, no decrement now
            st_nxt.ce       = st_r.cr;
            st_nxt.run      = 1'b1;
            st_nxt.frz      = 1'b0;
            st_nxt.null_cnt = 1'b0;
          end else if (st_r.run && st_r.smp_gate && !st_r.frz) begin
            st_nxt.ce = dec_one;
            // High at terminal count; keeps counting afterwards
            if (dec_one == smdc_pkg::CE_ZERO) begin
              st_nxt.out = 1'b1;
            end
          end
        end
        smdc_pkg::MODE_ONE_SHOT: begin
          if (st_r.smp_trig && st_r.armed) begin
            // Trigger or retrigger reloads and holds output low
            st_nxt.ce       = st_r.cr;
            st_nxt.run      = 1'b1;
            st_nxt.out      = 1'b0;
            st_nxt.null_cnt = 1'b0;
          end else if (st_r.run) begin
            st_nxt.ce = dec_one;
            if (dec_one == smdc_pkg::CE_ZERO) begin
              st_nxt.out = 1'b1;
            end
          end
        end
        smdc_pkg::MODE_RATE_GEN: begin
          if (st_r.smp_load || (st_r.smp_trig && st_r.armed)) begin
            // Initial load or gate resync, whatever the element holds
            st_nxt.ce       = st_r.cr;
            st_nxt.run      = 1'b1;
            st_nxt.out      = 1'b1;
            st_nxt.null_cnt = 1'b0;
          end else if (st_r.run && st_r.smp_gate) begin
            if (!st_r.out) begin
              // End of the low clock: reload with the latest count
              st_nxt.out      = 1'b1;
              st_nxt.ce       = st_r.cr;
              st_nxt.null_cnt = 1'b0;
            end else begin
              st_nxt.ce = dec_one;
              if (dec_one == smdc_pkg::CE_ONE) begin
                st_nxt.out = 1'b0;
              end
            end
          end
        end
        smdc_pkg::MODE_SQUARE: begin
          if (st_r.smp_load || (st_r.smp_trig && st_r.armed)) begin
            // Odd counts load one less, same as clearing the low bit
            st_nxt.ce       = cr_half;
            st_nxt.odd      = st_r.cr[0];
            st_nxt.run      = 1'b1;
            st_nxt.out      = 1'b1;
            st_nxt.null_cnt = 1'b0;
          end else if (st_r.run && st_r.smp_gate) begin
            if ((!st_r.odd && st_r.ce == smdc_pkg::CE_TWO) ||
                (st_r.odd && st_r.out && st_r.ce == smdc_pkg::CE_ZERO) ||
                (st_r.odd && !st_r.out && st_r.ce == smdc_pkg::CE_TWO)) begin
              // Level change takes up any newly written count
              st_nxt.out      = ~st_r.out;
              st_nxt.ce       = cr_half;
              st_nxt.odd      = st_r.cr[0];
              st_nxt.null_cnt = 1'b0;
            end else begin
              st_nxt.ce = dec_two;
            end
          end
        end
        smdc_pkg::MODE_SW_STROBE: begin
          if (st_r.smp_load) begin
            st_nxt.ce       = st_r.cr;
            st_nxt.run      = 1'b1;
            st_nxt.out      = 1'b1;
            st_nxt.null_cnt = 1'b0;
          end else if (st_r.run && st_r.smp_gate) begin
            // Gate only enables the decrement, never the output
            st_nxt.ce  = dec_one;
            st_nxt.out = (dec_one != smdc_pkg::CE_ZERO);
          end else begin
            st_nxt.out = 1'b1;
          end
        end
        smdc_pkg::MODE_HW_STROBE: begin
          if (st_r.smp_trig && st_r.armed) begin
            st_nxt.ce       = st_r.cr;
            st_nxt.run      = 1'b1;
            st_nxt.out      = 1'b1;
            st_nxt.null_cnt = 1'b0;
          end else if (st_r.run) begin
            st_nxt.ce  = dec_one;
            st_nxt.out = (dec_one != smdc_pkg::CE_ZERO);
          end
        end
        default: begin
          st_nxt.run = st_r.run;
        end
      endcase
    end

    // Control word write resets the channel control logic
    if (cw_wr && ({counter_control_word.byte_access_sel_hi,
                   counter_control_word.byte_access_sel_lo}
                  != smdc_pkg::RW_LATCH)) begin
      st_nxt.mode      = counter_control_word.mode;
      st_nxt.bcd       = counter_control_word.bcd;
      st_nxt.rw        = {counter_control_word.byte_access_sel_hi,
                          counter_control_word.byte_access_sel_lo};
      st_nxt.run       = 1'b0;
      st_nxt.load_pend = 1'b0;
      st_nxt.smp_load  = 1'b0;
      st_nxt.hi_next   = 1'b0;
      st_nxt.frz       = 1'b0;
      st_nxt.armed     = 1'b0;
      st_nxt.null_cnt  = 1'b1;
      // Mode 0 starts low, every other mode starts high
      st_nxt.out = (counter_control_word.mode !=
                    smdc_pkg::MODE_INT_TC);
    end else if (cnt_wr) begin
      // Count byte write
      if (st_r.rw == smdc_pkg::RW_BOTH) begin
        st_nxt.hi_next = ~st_r.hi_next;
        if (!st_r.hi_next) begin
          st_nxt.lo_stage = cnt_byte;
          // Mode 0 freezes between the two bytes
          if (mode_eff == smdc_pkg::MODE_INT_TC) begin
            st_nxt.frz = 1'b1;
          end
        end
      end
      if (mode_eff == smdc_pkg::MODE_INT_TC) begin
        st_nxt.out = 1'b0;
      end
      if (cnt_done) begin
        st_nxt.cr       = cr_new;
        st_nxt.armed    = 1'b1;
        st_nxt.null_cnt = 1'b1;
        // Modes 2 and 3 take a new count only at their next reload
        if ((mode_eff == smdc_pkg::MODE_INT_TC) ||
            (mode_eff == smdc_pkg::MODE_SW_STROBE) ||
            (((mode_eff == smdc_pkg::MODE_RATE_GEN) ||
              (mode_eff == smdc_pkg::MODE_SQUARE)) && !st_r.run)) begin
          st_nxt.load_pend = 1'b1;
        end
      end
    end

    // Gate low forces the output high at once in modes 2 and 3
    // Judged on the mode in force after this cycle's control word,
    // so a new mode 0 word still drives the output low
    if (st_nxt.mode[1] && !gate) begin
      st_nxt.out = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= '0;
      st_r.mode <= smdc_pkg::MODE_RST;
      st_r.cr   <= smdc_pkg::CR_RST;
      st_r.ce   <= smdc_pkg::CE_RST;
      st_r.out  <= smdc_pkg::OUT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ctr_out    = st_r.out;
  assign ce_value   = st_r.ce;
  assign null_count = st_r.null_cnt;

  // Mode 0 control word lowers the output next cycle
  property p_m0_cw_low;
    @(posedge clk) disable iff (!rst_n)
    (cw_wr && counter_control_word.mode == smdc_pkg::MODE_INT_TC &&
     counter_control_word.byte_access_sel_lo) |=> !ctr_out;
  endproperty
  a_m0_cw_low: assert property (p_m0_cw_low)
    else $error("mode 0 control word did not lower output");

  // Mode 0 load at the fall moves the count into the element
  property p_m0_load;
    @(posedge clk) disable iff (!rst_n)
    (fall && mode_eff == smdc_pkg::MODE_INT_TC && st_r.smp_load &&
     !cw_wr) |=> (ce_value == $past(st_r.cr));
  endproperty
  a_m0_load: assert property (p_m0_load)
    else $error("mode 0 load did not take the count");

  // Mode 0 gate low holds the element at a fall
  property p_m0_hold;
    @(posedge clk) disable iff (!rst_n)
    (fall && mode_eff == smdc_pkg::MODE_INT_TC && !st_r.smp_gate &&
     !st_r.smp_load && !cw_wr) |=> $stable(ce_value);
  endproperty
  a_m0_hold: assert property (p_m0_hold)
    else $error("mode 0 element moved with gate low");

  // Mode 1 output ignores count writes
  property p_m1_write;
    @(posedge clk) disable iff (!rst_n)
    (cnt_wr && !cw_wr && !fall && mode_eff == smdc_pkg::MODE_ONE_SHOT)
    |=> (ctr_out == $past(ctr_out));
  endproperty
  a_m1_write: assert property (p_m1_write)
    else $error("mode 1 output moved on a count write");

  // Gate low in modes 2 and 3 gives a high output next cycle
  property p_gate_high;
    @(posedge clk) disable iff (!rst_n)
    ((mode_eff == smdc_pkg::MODE_RATE_GEN ||
      mode_eff == smdc_pkg::MODE_SQUARE) && !gate && !cw_wr) |=> ctr_out;
  endproperty
  a_gate_high: assert property (p_gate_high)
    else $error("gate low did not force output high");

  // Square wave element always holds an even value while running
  property p_m3_even;
    @(posedge clk) disable iff (!rst_n)
    (mode_eff == smdc_pkg::MODE_SQUARE && st_r.run) |-> !ce_value[0];
  endproperty
  a_m3_even: assert property (p_m3_even)
    else $error("square wave element holds an odd value");

  // Mode 4 low output lasts only until the next fall
  property p_m4_pulse;
    @(posedge clk) disable iff (!rst_n)
    (fall && mode_eff == smdc_pkg::MODE_SW_STROBE && !ctr_out &&
     !cw_wr && !cnt_wr) |=> ctr_out;
  endproperty
  a_m4_pulse: assert property (p_m4_pulse)
    else $error("mode 4 low pulse longer than one clock");

  // Edge flag is gone the cycle after its sampling rise
  property p_trig_clear;
    @(posedge clk) disable iff (!rst_n)
    (rise && !(gate && !$past(gate))) |=> !trig_flag;
  endproperty
  a_trig_clear: assert property (p_trig_clear)
    else $error("gate edge flag not cleared after sampling");

  // Decimal element wraps from zero to 9999 in mode 0
  property p_bcd_wrap;
    @(posedge clk) disable iff (!rst_n)
    (fall && st_r.bcd && mode_eff == smdc_pkg::MODE_INT_TC && st_r.run &&
     st_r.smp_gate && !st_r.smp_load && !st_r.frz && !cw_wr &&
     ce_value == smdc_pkg::CE_ZERO) |=> (ce_value == 16'h9999);
  endproperty
  a_bcd_wrap: assert property (p_bcd_wrap)
    else $error("decimal element did not wrap to 9999");

endmodule : smdc_counter
`default_nettype wire

// ===== verif/smdc_far_end.sv
`default_nettype none
// Far side: counter clock source and gate driver
module smdc_far_end (
  input  wire logic clk,     // System clock
  output var  logic ctr_clk, // Counter clock, idle low between ticks
  output var  logic gate     // Gate level
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle levels at time zero
  initial begin
    ctr_clk = 1'b0;
    gate    = 1'b0;
  end

  // One counter clock: three system clocks high, three low
  task automatic tick();
    @(negedge clk);
    ctr_clk = 1'b1;
    repeat (3) @(negedge clk);
    ctr_clk = 1'b0;
    repeat (3) @(negedge clk);
  endtask : tick

  // Gate level changes just after a falling system clock
  task automatic set_gate(input logic lvl);
    @(negedge clk);
    gate = lvl;
  endtask : set_gate
endmodule : smdc_far_end
`default_nettype wire

// ===== verif/six_mode_down_counter_tb.sv
`default_nettype none
// Self-checking bench of the six-mode down counter
module six_mode_down_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic               clk;             // System clock
  logic               arst_n;          // Reset, active low
  logic               ctr_clk;         // Counter clock
  logic               gate;            // Gate level
  logic               cw_wr;           // Control word strobe
  smdc_pkg::smdc_cw_t cw;              // Control word
  logic               cnt_wr;          // Count byte strobe
  logic [7:0]         cnt_byte;        // Count byte
  logic               ctr_out;         // Output line
  logic [15:0]        ce_value;        // Counting element
  logic               null_count;      // Count not yet loaded
  logic [18:0]        exp_q[$];        // Notes: ce known, null, out, ce
  int                 mismatches;      // Failed compares
  int                 samples_checked; // Compares made
  int                 cycles = 0;      // Hang guard
  int                 n;               // Random count
  int                 k;               // Loop index
  logic [7:0]         lo_b;            // Random low count byte

  smdc_counter smdc_counter_i (
    .clk(clk), .arst_n(arst_n), .ctr_clk(ctr_clk), .gate(gate),
    .cw_wr(cw_wr), .counter_control_word(cw), .cnt_wr(cnt_wr),
    .cnt_byte(cnt_byte), .ctr_out(ctr_out), .ce_value(ce_value),
    .null_count(null_count)
  );
  smdc_far_end smdc_far_end_i (.clk(clk), .ctr_clk(ctr_clk), .gate(gate));

  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Compare one result against its note
  task automatic check(input logic [17:0] seen, input logic [17:0] want);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  // Verdict and end of run
  task automatic stop_test();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  // Monitor: takes the oldest note and compares it with the outputs
  initial begin
    logic [18:0] e;
    forever begin
      wait (exp_q.size() != 0);
      e = exp_q.pop_front();
      check({null_count, ctr_out, ce_value},
            {e[17:16], e[18] ? e[15:0] : ce_value});
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      stop_test();
    end
  end

  // Record one expected result
  task automatic note(input logic kc, input logic nl, input logic o,
                      input logic [15:0] c);
    exp_q.push_back({kc, nl, o, c});
  endtask : note

  // Control word with chosen byte access and decimal select
  task automatic wr_cwx(input logic [1:0] rw, input logic [2:0] m,
                        input logic b);
    cw    = smdc_pkg::smdc_cw_t'({rw, m, b});
    cw_wr = 1'b1;
    @(negedge clk);
    cw_wr = 1'b0;
  endtask : wr_cwx

  // Control word, low byte access only
  task automatic wr_cw(input logic [2:0] m);
    wr_cwx(smdc_pkg::RW_LSB, m, 1'b0);
  endtask : wr_cw

  // One count byte
  task automatic wr_cnt(input logic [7:0] b);
    cnt_byte = b;
    cnt_wr   = 1'b1;
    @(negedge clk);
    cnt_wr   = 1'b0;
  endtask : wr_cnt

  // Counter clocks with nibble-packed element values, out and null bits
  task automatic play(input int t, input logic [31:0] ces,
                      input logic [7:0] outs, input logic [7:0] nuls);
    for (int i = 0; i < t; i++) begin
      smdc_far_end_i.tick();
      note(1'b1, nuls[i], outs[i], {12'h000, ces[4*i+:4]});
    end
  endtask : play

  // Main sequence
  initial begin
    void'($urandom(65));
    arst_n   = 1'b0;
    cw       = '0;
    cw_wr    = 1'b0;
    cnt_wr   = 1'b0;
    cnt_byte = 8'h00;
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    note(1'b1, 1'b0, 1'b1, 16'h0000);
    repeat (3) @(negedge clk);
    // Mode 0 with a random count
    smdc_far_end_i.set_gate(1'b1);
    n = 3 + ($urandom % 4);
    wr_cw(smdc_pkg::MODE_INT_TC);
    wr_cnt(8'(n));
    note(1'b0, 1'b1, 1'b0, 16'h0000);
    smdc_far_end_i.tick();
    note(1'b1, 1'b0, 1'b0, 16'(n));
    smdc_far_end_i.set_gate(1'b0);
    smdc_far_end_i.tick();
    note(1'b1, 1'b0, 1'b0, 16'(n));
    smdc_far_end_i.set_gate(1'b1);
    for (k = n - 1; k > 0; k--) begin
      smdc_far_end_i.tick();
      note(1'b1, 1'b0, 1'b0, 16'(k));
    end
    play(1, 32'h0, 8'h01, 8'h00);
    smdc_far_end_i.tick();
    note(1'b1, 1'b0, 1'b1, 16'hffff);
    wr_cnt(8'h02);
    note(1'b0, 1'b1, 1'b0, 16'h0000);
    play(1, 32'h2, 8'h00, 8'h00);
    // Mode 2, counts of two or more only
    wr_cw(smdc_pkg::MODE_RATE_GEN);
    wr_cnt(8'h03);
    play(2, 32'h23, 8'h03, 8'h00);
    wr_cnt(8'h05);
    play(6, 32'h0012_3451, 8'h1e, 8'h01);
    smdc_far_end_i.set_gate(1'b0);
    repeat (3) @(negedge clk);
    note(1'b1, 1'b0, 1'b1, 16'h0001);
    smdc_far_end_i.set_gate(1'b1);
    play(1, 32'h5, 8'h01, 8'h00);
    // Mode 3, even then odd count
    wr_cw(smdc_pkg::MODE_SQUARE);
    wr_cnt(8'h04);
    play(5, 32'h0004_2424, 8'h13, 8'h00);
    wr_cw(smdc_pkg::MODE_SQUARE);
    wr_cnt(8'h05);
    play(6, 32'h0042_4024, 8'h27, 8'h00);
    // Mode 4 strobe, reload and gate hold
    wr_cw(smdc_pkg::MODE_SW_STROBE);
    wr_cnt(8'h02);
    play(3, 32'h012, 8'h03, 8'h00);
    smdc_far_end_i.tick();
    note(1'b1, 1'b0, 1'b1, 16'hffff);
    wr_cnt(8'h03);
    play(1, 32'h3, 8'h01, 8'h00);
    smdc_far_end_i.set_gate(1'b0);
    play(1, 32'h3, 8'h01, 8'h00);
    // Mode 5, trigger loads
    wr_cw(smdc_pkg::MODE_HW_STROBE);
    wr_cnt(8'h02);
    smdc_far_end_i.tick();
    note(1'b0, 1'b1, 1'b1, 16'h0000);
    smdc_far_end_i.set_gate(1'b1);
    play(3, 32'h012, 8'h03, 8'h00);
    // Mode 1 one-shot
    smdc_far_end_i.set_gate(1'b0);
    wr_cw(smdc_pkg::MODE_ONE_SHOT);
    wr_cnt(8'h02);
    smdc_far_end_i.tick();
    note(1'b0, 1'b1, 1'b1, 16'h0000);
    smdc_far_end_i.set_gate(1'b1);
    play(3, 32'h012, 8'h04, 8'h00);
    // Decimal mode 0: count one, then wrap below zero
    wr_cwx(smdc_pkg::RW_LSB, smdc_pkg::MODE_INT_TC, 1'b1);
    wr_cnt(8'h01);
    play(2, 32'h01, 8'h02, 8'h00);
    smdc_far_end_i.tick();
    note(1'b1, 1'b0, 1'b1, 16'h9999);
    // Two-byte mode 0: low byte freezes, high byte loads
    lo_b = 8'($urandom);
    wr_cwx(smdc_pkg::RW_BOTH, smdc_pkg::MODE_INT_TC, 1'b0);
    wr_cnt(lo_b);
    @(negedge clk);
    wr_cnt(8'hff);
    smdc_far_end_i.tick();
    note(1'b1, 1'b0, 1'b0, {8'hff, lo_b});
    smdc_far_end_i.tick();
    note(1'b1, 1'b0, 1'b0, {8'hff, lo_b} - 16'h0001);
    wr_cnt(8'h07);
    smdc_far_end_i.tick();
    note(1'b1, 1'b0, 1'b0, {8'hff, lo_b} - 16'h0001);
    wr_cnt(8'h00);
    play(1, 32'h7, 8'h00, 8'h00);
    // Latch command leaves mode and count alone
    wr_cwx(smdc_pkg::RW_LATCH, smdc_pkg::MODE_RATE_GEN, 1'b1);
    play(1, 32'h6, 8'h00, 8'h00);
    wait (exp_q.size() == 0);
    @(negedge clk);
    stop_test();
  end
endmodule : six_mode_down_counter_tb
`default_nettype wire
